// ==== core/liu_diag.sv ====
// Diagnostics of a line interface unit: pattern test, error counter, loopbacks, all-ones
// Summary of operation
// - Pattern mode sends 2^23-1 or 2^15-1 sequence
// - Pattern test only works in host mode
// - Pattern mode enables detector; violation low when synced
// - Out of sync sets lost flag, violation high
// - Each 0-to-1 insert write injects one error
// - Each detected error pulses violation output high
// - Sixteen-bit counter counts detected errors, saturating at 0xFFFF
// - First byte read copies other byte, clears both
// - Counter bytes clear on read, high 0x30
// - Global interrupt enable bit, reset zero
// - Pending bit shows interrupt needing service
// - Fixed identifier and revision registers
// - Loopback from pins in hardware, bits in host
// - Analog loop feeds transmit back, ignores line
// - Analog loop bypasses the jitter attenuator
// - Digital loop returns system transmit to receive
// - Remote loop returns line data, ignores system
// - Remote loop with transmit attenuator uses recovered data
// - All-ones sends alternating marks at transmit rate
// - All-ones from pin or control bit
`timescale 1ns/10ps
`include "liu_diag_defs.svh"
module liu_diag
  import liu_diag_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       host_mode,
  input  wire logic       rate_is_e3,
  input  wire logic       hw_remote_loop,
  input  wire logic       hw_local_loop,
  input  wire logic       hw_transmit_all_ones,
  input  wire logic       ja_in_tx_path,
  input  wire logic       source_irq_pending,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       tx_positive_data_in,
  input  wire logic       tx_negative_data_in,
  input  wire logic       line_rx_positive,
  input  wire logic       line_rx_negative,
  input  wire logic       rx_ja_positive,
  input  wire logic       rx_ja_negative,
  output logic            line_tx_positive,
  output logic            line_tx_negative,
  output logic            rx_positive_data_out,
  output logic            rx_negative_or_violation_out,
  output logic            receive_clock_from_tx,
  output logic            tx_timing_from_rx,
  output logic            irq_out
);
  pattern_if pat ();

  logic [7:0]  ctrl_ff;
  logic        irq_enable_ff;
  logic [15:0] err_count_ff;
  logic [7:0]  err_hold_ff;
  logic        insert_last_ff;
  logic        ones_phase_ff;
  logic [7:0]  reg_rdata_ff;
  logic        line_tx_pos_ff;
  logic        line_tx_neg_ff;
  logic        rx_pos_ff;
  logic        rx_neg_ff;
  logic        irq_ff;
  loop_mode_t  loop_mode;

  wire         wr_ctrl     = reg_wr && (reg_addr == `ADDR_CHAN_CTRL);
  wire         wr_irq_en   = reg_wr && (reg_addr == `ADDR_IRQ_ENABLE);
  wire         rd_err_high = reg_rd && (reg_addr == `ADDR_ERR_HIGH);
  wire         rd_err_low  = reg_rd && (reg_addr == `ADDR_ERR_LOW);
  wire         rd_err_any  = rd_err_high || rd_err_low;

  wire         pattern_mode_enable  = host_mode && ctrl_ff[`CTL_PATTERN_EN];
  wire         pattern_error_insert = ctrl_ff[`CTL_ERR_INSERT];
  wire         transmit_all_ones    = host_mode ? ctrl_ff[`CTL_ALL_ONES]
                                                : hw_transmit_all_ones;
  wire         remote_loop_select   = host_mode ? ctrl_ff[`CTL_REMOTE_LOOP]
                                                : hw_remote_loop;
  wire         local_loop_select    = host_mode ? ctrl_ff[`CTL_LOCAL_LOOP]
                                                : hw_local_loop;
  wire         pattern_sync_lost    = pattern_mode_enable && !pat.in_sync;
  wire         global_irq_pending   = source_irq_pending;
  wire         insert_rise          = pattern_error_insert && !insert_last_ff;

  always_comb begin
    case ({remote_loop_select, local_loop_select})
      2'b00:   loop_mode = LOOP_NORMAL;
      2'b01:   loop_mode = LOOP_ANALOG;
      2'b10:   loop_mode = LOOP_REMOTE;
      2'b11:   loop_mode = LOOP_DIGITAL;
      default: loop_mode = LOOP_NORMAL;
    endcase
  end

  wire         mode_analog  = (loop_mode == LOOP_ANALOG);
  wire         mode_remote  = (loop_mode == LOOP_REMOTE);
  wire         mode_digital = (loop_mode == LOOP_DIGITAL);

  // Receive path after the attenuator when it sits there, else straight recovered data
  wire         rx_post_pos  = ja_in_tx_path ? line_rx_positive : rx_ja_positive;
  wire         rx_post_neg  = ja_in_tx_path ? line_rx_negative : rx_ja_negative;
  // Analog loop takes our own line drive back in place of the line inputs
  wire         rx_src_pos   = mode_analog ? line_tx_pos_ff : rx_post_pos;
  wire         rx_src_neg   = mode_analog ? line_tx_neg_ff : rx_post_neg;
  // Remote loop taps before the attenuator when it is on the transmit side,
  // so the looped data still passes it on the way out
  wire         loop_pos     = rx_post_pos;
  wire         loop_neg     = rx_post_neg;

  // Transmit priority: all-ones, remote loop, digital loop (line idle), pattern, system
  wire         nxt_tx_pos   = transmit_all_ones   ? ones_phase_ff :
                              mode_remote         ? loop_pos :
                              mode_digital        ? 1'b0 :
                              pattern_mode_enable ? pat.tx_bit :
                              tx_positive_data_in;
  wire         nxt_tx_neg   = transmit_all_ones   ? !ones_phase_ff :
                              mode_remote         ? loop_neg :
                              mode_digital        ? 1'b0 :
                              pattern_mode_enable ? 1'b0 :
                              tx_negative_data_in;

  wire         nxt_rx_pos   = mode_digital ? tx_positive_data_in : rx_src_pos;
  // Violation output is steady high out of sync and pulses on each detected error
  wire         nxt_rx_neg   = pattern_mode_enable ? (!pat.in_sync || pat.bit_err)
                              : mode_digital ? tx_negative_data_in : rx_src_neg;

  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `ADDR_CHAN_CTRL:   rd_mux = ctrl_ff;
      `ADDR_CHAN_STAT:   rd_mux = {7'h00, pattern_sync_lost};
      `ADDR_IRQ_ENABLE:  rd_mux = {7'h00, irq_enable_ff};
      `ADDR_IRQ_PENDING: rd_mux = {7'h00, global_irq_pending};
      `ADDR_ERR_HIGH:    rd_mux = err_count_ff[15:8];
      `ADDR_ERR_LOW:     rd_mux = err_count_ff[7:0];
      `ADDR_ERR_HOLD:    rd_mux = err_hold_ff;
      `ADDR_DEV_ID:      rd_mux = `DEV_ID_VALUE;
      `ADDR_DEV_REV:     rd_mux = `DEV_REV_VALUE;
      default:           rd_mux = `BYTE_ZERO;
    endcase
  end

  // An error landing in the clearing cycle survives as a count of one
  wire [15:0]  nxt_err_count = rd_err_any ? (pat.bit_err ? `COUNT_ONE : `COUNT_ZERO)
                             : (pattern_mode_enable && pat.bit_err
                                && err_count_ff != `COUNT_MAX)
                               ? err_count_ff + `COUNT_ONE
                               : err_count_ff;
  wire [7:0]   nxt_err_hold  = rd_err_high ? err_count_ff[7:0] :
                               rd_err_low  ? err_count_ff[15:8] : err_hold_ff;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_ff        <= `CTRL_RESET;
      irq_enable_ff  <= 1'b0;
      insert_last_ff <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) ctrl_ff <= reg_wdata;
      if (wr_irq_en) irq_enable_ff <= reg_wdata[`IRQ_ENABLE_BIT];
      insert_last_ff <= pattern_error_insert;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      err_count_ff <= `COUNT_ZERO;
      err_hold_ff  <= `BYTE_ZERO;
      reg_rdata_ff <= `BYTE_ZERO;
    end else if (ce) begin
      err_count_ff <= nxt_err_count;
      err_hold_ff  <= nxt_err_hold;
      if (reg_rd) reg_rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ones_phase_ff  <= 1'b0;
      line_tx_pos_ff <= 1'b0;
      line_tx_neg_ff <= 1'b0;
      rx_pos_ff      <= 1'b0;
      rx_neg_ff      <= 1'b0;
      irq_ff         <= 1'b0;
    end else if (ce) begin
      ones_phase_ff  <= transmit_all_ones ? !ones_phase_ff : 1'b0;
      line_tx_pos_ff <= nxt_tx_pos;
      line_tx_neg_ff <= nxt_tx_neg;
      rx_pos_ff      <= nxt_rx_pos;
      rx_neg_ff      <= nxt_rx_neg;
      irq_ff         <= irq_enable_ff && global_irq_pending;
    end
  end

  assign pat.enable       = pattern_mode_enable;
  assign pat.long_seq     = rate_is_e3;
  assign pat.insert_pulse = pattern_mode_enable && insert_rise;
  assign pat.rx_bit       = rx_src_pos;

  pattern_gen u_gen (
    .mclk  (mclk),
    .rst_b (rst_b),
    .ce    (ce),
    .pat   (pat.gen)
  );

  pattern_chk u_chk (
    .mclk  (mclk),
    .rst_b (rst_b),
    .ce    (ce),
    .pat   (pat.chk)
  );

  assign reg_rdata                   = reg_rdata_ff;
  assign line_tx_positive            = line_tx_pos_ff;
  assign line_tx_negative            = line_tx_neg_ff;
  assign rx_positive_data_out        = rx_pos_ff;
  assign rx_negative_or_violation_out = rx_neg_ff;
  assign receive_clock_from_tx       = mode_digital;
  assign tx_timing_from_rx           = mode_remote && !transmit_all_ones;
  assign irq_out                     = irq_ff;

  AST_PATTERN_HOST_ONLY: assert property (@(posedge mclk) disable iff (!rst_b)
    !host_mode |-> !pat.enable) else $error("pattern engine enabled outside host mode");

  AST_INSERT_SINGLE: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && pat.insert_pulse) |=> !pat.insert_pulse)
    else $error("error insertion lasted more than one cycle");

  AST_VIOLATION_OUT_OF_SYNC: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && pattern_mode_enable && !pat.in_sync) |=> rx_negative_or_violation_out)
    else $error("violation output low while out of sync");

  AST_VIOLATION_PULSE: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && pattern_mode_enable && pat.in_sync && !pat.bit_err) |=> !rx_negative_or_violation_out)
    else $error("violation output high while synced and error free");

  AST_COUNT_STEP: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && pattern_mode_enable && pat.bit_err && !rd_err_any && err_count_ff != `COUNT_MAX)
    |=> err_count_ff == $past(err_count_ff) + `COUNT_ONE)
    else $error("error counter did not step by one");

  AST_READ_CLEARS: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && rd_err_any && !pat.bit_err) |=> err_count_ff == `COUNT_ZERO)
    else $error("counter not cleared by byte read");

  AST_HOLD_COPY: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && rd_err_high) |=> err_hold_ff == $past(err_count_ff[7:0]))
    else $error("holding register missed the unread low byte");

  AST_IRQ_GATED: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && !irq_enable_ff) |=> !irq_out) else $error("interrupt raised while disabled");

  AST_ALL_ONES_ALT: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && transmit_all_ones) [*2] |=> line_tx_positive != line_tx_negative
    && line_tx_positive != $past(line_tx_positive))
    else $error("all-ones output is not alternating marks");

  AST_DIGITAL_LOOP: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && mode_digital && !transmit_all_ones) |=> !line_tx_positive && !line_tx_negative
    && rx_positive_data_out == $past(tx_positive_data_in))
    else $error("digital loop routing wrong");

  AST_ANALOG_LOOP: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && mode_analog) |=> rx_positive_data_out == $past(line_tx_positive))
    else $error("analog loop did not return the line drive");

  AST_REMOTE_LOOP: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && mode_remote && !transmit_all_ones && !pattern_mode_enable)
    |=> line_tx_positive == rx_positive_data_out
    && line_tx_negative == rx_negative_or_violation_out)
    else $error("remote loop output differs from receive output");

  AST_NORMAL_PATH: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && loop_mode == LOOP_NORMAL && !transmit_all_ones && !pattern_mode_enable)
    |=> line_tx_positive == $past(tx_positive_data_in))
    else $error("normal mode did not send system data");

  AST_ERROR_PULSE: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && pattern_mode_enable && pat.bit_err) |=> rx_negative_or_violation_out)
    else $error("detected error gave no violation pulse");

  AST_HOLD_COPY_HIGH: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && rd_err_low) |=> err_hold_ff == $past(err_count_ff[15:8]))
    else $error("holding register missed the unread high byte");

  AST_IRQ_RAISE: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && irq_enable_ff && global_irq_pending) |=> irq_out)
    else $error("enabled pending interrupt not raised");

  AST_DEVICE_ID: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && reg_rd && reg_addr == `ADDR_DEV_ID) |=> reg_rdata == `DEV_ID_VALUE)
    else $error("identifier register read wrong");

  AST_DEVICE_REV: assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && reg_rd && reg_addr == `ADDR_DEV_REV) |=> reg_rdata == `DEV_REV_VALUE)
    else $error("revision register read wrong");

endmodule : liu_diag

// ==== core/liu_diag_defs.svh ====
// Register offsets, field positions, reset values and counts of the diagnostic block
`ifndef LIU_DIAG_DEFS_SVH
`define LIU_DIAG_DEFS_SVH

`define ADDR_CHAN_CTRL   8'h04
`define ADDR_CHAN_STAT   8'h05
`define ADDR_IRQ_ENABLE  8'h20
`define ADDR_IRQ_PENDING 8'h21
`define ADDR_ERR_HIGH    8'h30
`define ADDR_ERR_LOW     8'h31
`define ADDR_ERR_HOLD    8'h38
`define ADDR_DEV_ID      8'h3E
`define ADDR_DEV_REV     8'h3F

`define CTL_ERR_INSERT   0
`define CTL_ALL_ONES     1
`define CTL_LOCAL_LOOP   3
`define CTL_REMOTE_LOOP  4
`define CTL_PATTERN_EN   5
`define STAT_SYNC_LOST   0
`define IRQ_ENABLE_BIT   0
`define IRQ_PENDING_BIT  0

`define CTRL_RESET       8'h00
`define BYTE_ZERO        8'h00
`define COUNT_ZERO       16'h0000
`define COUNT_MAX        16'hFFFF
`define COUNT_ONE        16'h0001

// Identifier and revision values are arbitrary
`define DEV_ID_VALUE     8'hA5
`define DEV_REV_VALUE    8'h3C

`define LFSR_SEED        23'h7FFFFF
`define LFSR_ZERO        23'h000000
`define LONG_TAP_A       22
`define LONG_TAP_B       17
`define SHORT_TAP_A      14
`define SHORT_TAP_B      13

`define GOOD_ZERO        6'h00
`define GOOD_FOR_SYNC    6'h20
`define BAD_ZERO         4'h0
`define BAD_FOR_LOSS     4'h8

`endif

// ==== core/liu_diag_pkg.sv ====
// Types shared by the diagnostic block
package liu_diag_pkg;

  typedef enum logic [3:0] {
    LOOP_NORMAL  = 4'b0001,
    LOOP_ANALOG  = 4'b0010,
    LOOP_REMOTE  = 4'b0100,
    LOOP_DIGITAL = 4'b1000
  } loop_mode_t;

  typedef enum logic [1:0] {
    SYNC_HUNT   = 2'b01,
    SYNC_LOCKED = 2'b10
  } sync_state_t;

endpackage : liu_diag_pkg

// ==== core/pattern_chk.sv ====
// Pattern detector: acquires the sequence, flags bit errors and tracks sync
`timescale 1ns/10ps
`include "liu_diag_defs.svh"
module pattern_chk
  import liu_diag_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  pattern_if.chk   pat
);
  sync_state_t state_ff;
  sync_state_t nxt_state;
  logic [22:0] ref_ff;
  logic [5:0]  good_ff;
  logic [3:0]  bad_ff;
  logic        pred;
  logic        miss;
  logic        good_run;

  assign pred     = pat.long_seq ? (ref_ff[`LONG_TAP_A] ^ ref_ff[`LONG_TAP_B])
                                 : (ref_ff[`SHORT_TAP_A] ^ ref_ff[`SHORT_TAP_B]);
  assign miss     = pat.rx_bit != pred;
  // An all-zero reference would lock onto a dead line, so it never counts as good
  assign good_run = !miss && (ref_ff != `LFSR_ZERO);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SYNC_HUNT:   if (good_run && good_ff == `GOOD_FOR_SYNC) nxt_state = SYNC_LOCKED;
      SYNC_LOCKED: if (miss && bad_ff == `BAD_FOR_LOSS - 4'h1) nxt_state = SYNC_HUNT;
      default:     nxt_state = SYNC_HUNT;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b || !pat.enable) begin
      state_ff    <= SYNC_HUNT;
      ref_ff      <= `LFSR_ZERO;
      good_ff     <= `GOOD_ZERO;
      bad_ff      <= `BAD_ZERO;
      pat.bit_err <= 1'b0;
    end else if (ce) begin
      state_ff    <= nxt_state;
      // Free-running while locked so one line error is counted once, not per tap
      ref_ff      <= {ref_ff[21:0], (state_ff == SYNC_LOCKED) ? pred : pat.rx_bit};
      good_ff     <= !good_run ? `GOOD_ZERO :
                     (good_ff == `GOOD_FOR_SYNC) ? good_ff : good_ff + 6'h01;
      bad_ff      <= (good_ff == `GOOD_FOR_SYNC) ? `BAD_ZERO :
                     miss ? bad_ff + 4'h1 : bad_ff;
      pat.bit_err <= miss;
    end
  end

  assign pat.in_sync = (state_ff == SYNC_LOCKED);
endmodule : pattern_chk

// ==== core/pattern_gen.sv ====
// Pseudo-random pattern generator with single-bit error insertion
`timescale 1ns/10ps
`include "liu_diag_defs.svh"
module pattern_gen
  import liu_diag_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  pattern_if.gen   pat
);
  logic [22:0] lfsr_ff;
  logic        fb;

  // Long sequence 2^23-1, short 2^15-1
  assign fb = pat.long_seq ? (lfsr_ff[`LONG_TAP_A] ^ lfsr_ff[`LONG_TAP_B])
                           : (lfsr_ff[`SHORT_TAP_A] ^ lfsr_ff[`SHORT_TAP_B]);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      lfsr_ff    <= `LFSR_SEED;
      pat.tx_bit <= 1'b0;
    end else if (ce) begin
      if (pat.enable) begin
        lfsr_ff    <= {lfsr_ff[21:0], fb};
        pat.tx_bit <= fb ^ pat.insert_pulse;
      end else begin
        lfsr_ff    <= `LFSR_SEED;
        pat.tx_bit <= 1'b0;
      end
    end
  end
endmodule : pattern_gen

// ==== core/pattern_if.sv ====
// Pattern generator and detector signals between the top and its two engines
`timescale 1ns/10ps
interface pattern_if;
  logic enable;
  logic long_seq;
  logic insert_pulse;
  logic tx_bit;
  logic rx_bit;
  logic bit_err;
  logic in_sync;

  modport gen (input enable, input long_seq, input insert_pulse, output tx_bit);
  modport chk (input enable, input long_seq, input rx_bit, output bit_err, output in_sync);
  modport top (output enable, output long_seq, output insert_pulse, output rx_bit,
               input tx_bit, input bit_err, input in_sync);
endinterface : pattern_if

// ==== verification/line_partner.sv ====
// Behavioural line transceiver and system framer facing the diagnostic block
`timescale 1ns/10ps
module line_partner (
  input  wire logic mclk,
  input  wire logic rst_b,
  output logic      line_rx_positive,
  output logic      line_rx_negative,
  output logic      rx_ja_positive,
  output logic      rx_ja_negative,
  output logic      tx_positive_data_in,
  output logic      tx_negative_data_in
);
  logic [2:0] phase_ff;

  always_ff @(posedge mclk) begin
    if (!rst_b)
      phase_ff <= 3'h0;
    else
      phase_ff <= phase_ff + 3'h1;
  end

  // Streams of different periods, so a wrong source or a one-cycle slip shows up
  assign line_rx_positive    = phase_ff[1];
  assign line_rx_negative    = ~phase_ff[1];
  assign rx_ja_positive      = phase_ff[0];
  assign rx_ja_negative      = ~phase_ff[0];
  assign tx_positive_data_in = phase_ff[2];
  assign tx_negative_data_in = ~phase_ff[2];
endmodule : line_partner

// ==== verification/test_liu_diagnostics_prbs_loopback.sv ====
// Self-checking bench for the line interface diagnostic block
`timescale 1ns/10ps
`include "liu_diag_defs.svh"
module test_liu_diagnostics_prbs_loopback
  import liu_diag_pkg::*;
;
  logic        mclk, rst_b, ce, host_mode, rate_is_e3, hw_remote_loop, hw_local_loop;
  logic        hw_transmit_all_ones, ja_in_tx_path, source_irq_pending, reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic        tx_positive_data_in, tx_negative_data_in, line_rx_positive, line_rx_negative;
  logic        rx_ja_positive, rx_ja_negative, line_tx_positive, line_tx_negative;
  logic        rx_positive_data_out, rx_negative_or_violation_out, irq_out;
  logic        receive_clock_from_tx, tx_timing_from_rx, prev_sys, prev_line, prev_ja, prev_tx;
  logic [31:0] first_bits, later_bits;
  int          n_fail, comparisons;

  liu_diag uut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .host_mode(host_mode),
    .rate_is_e3(rate_is_e3), .hw_remote_loop(hw_remote_loop), .hw_local_loop(hw_local_loop),
    .hw_transmit_all_ones(hw_transmit_all_ones), .ja_in_tx_path(ja_in_tx_path),
    .source_irq_pending(source_irq_pending), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_positive_data_in(tx_positive_data_in), .tx_negative_data_in(tx_negative_data_in),
    .line_rx_positive(line_rx_positive), .line_rx_negative(line_rx_negative),
    .rx_ja_positive(rx_ja_positive), .rx_ja_negative(rx_ja_negative),
    .line_tx_positive(line_tx_positive), .line_tx_negative(line_tx_negative),
    .rx_positive_data_out(rx_positive_data_out),
    .rx_negative_or_violation_out(rx_negative_or_violation_out),
    .receive_clock_from_tx(receive_clock_from_tx), .tx_timing_from_rx(tx_timing_from_rx),
    .irq_out(irq_out));

  line_partner line_side (.mclk(mclk), .rst_b(rst_b), .line_rx_positive(line_rx_positive),
    .line_rx_negative(line_rx_negative), .rx_ja_positive(rx_ja_positive),
    .rx_ja_negative(rx_ja_negative), .tx_positive_data_in(tx_positive_data_in),
    .tx_negative_data_in(tx_negative_data_in));

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // What the registered outputs should have taken at the last edge
  always @(posedge mclk) begin
    prev_sys  <= tx_positive_data_in;
    prev_line <= line_rx_positive;
    prev_ja   <= rx_ja_positive;
    prev_tx   <= line_tx_positive;
  end

  task cyc;
    @(posedge mclk);
    #1;
  endtask : cyc

  task chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t bit got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t byte got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  // Strobe dropped and a full edge let pass, so back-to-back calls never re-raise it at once
  task reg_write(input logic [7:0] a, input logic [7:0] v);
    reg_addr  = a;
    reg_wdata = v;
    reg_wr    = 1'h1;
    cyc;
    reg_wr = 1'h0;
    cyc;
  endtask : reg_write

  task reg_read(input logic [7:0] a, output logic [7:0] v);
    reg_addr = a;
    reg_rd   = 1'h1;
    cyc;
    reg_rd = 1'h0;
    v      = reg_rdata;
    cyc;
  endtask : reg_read

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    reg_read(a, v);
    chk_byte(v, exp);
  endtask : rd_chk

  task check_path(input logic [1:0] code);
    cyc;
    repeat (4) begin
      cyc;
      chk_bit(receive_clock_from_tx, code == 2'h3);
      chk_bit(tx_timing_from_rx, code == 2'h2);
      if (code == 2'h3) begin
        chk_bit(rx_positive_data_out, prev_sys);
        chk_bit(line_tx_positive, 1'h0);
      end else if (code == 2'h2) begin
        chk_bit(line_tx_positive, ja_in_tx_path ? prev_line : prev_ja);
      end else begin
        chk_bit(line_tx_positive, prev_sys);
      end
      if (code == 2'h0 || code == 2'h2)
        chk_bit(rx_positive_data_out, ja_in_tx_path ? prev_line : prev_ja);
      if (code == 2'h1)
        chk_bit(rx_positive_data_out, prev_tx);
    end
  endtask : check_path

  task check_all_ones;
    logic last;
    repeat (2) cyc;
    last = line_tx_positive;
    repeat (6) begin
      cyc;
      chk_bit(line_tx_positive ^ line_tx_negative, 1'h1);
      chk_bit(line_tx_positive, ~last);
      last = line_tx_positive;
    end
  endtask : check_all_ones

  task count_pulses(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (16) begin
      cyc;
      if (rx_negative_or_violation_out === 1'h1)
        n = n + 8'h01;
    end
    chk_byte(n, exp);
  endtask : count_pulses

  task wait_sync;
    int k;
    k = 0;
    while (rx_negative_or_violation_out !== 1'h0 && k < 300) begin
      cyc;
      k++;
    end
    chk_bit(rx_negative_or_violation_out, 1'h0);
  endtask : wait_sync

  task test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // Longest test is one full short sequence of 32767 bits; the rest is well under 10000
  initial begin
    repeat (45000) @(posedge mclk);
    n_fail++;
    $display("ERROR %0t run did not finish", $time);
    test_done;
  end

  initial begin
    {rst_b, ce, host_mode, rate_is_e3, hw_remote_loop, hw_local_loop} = 6'h01;
    {hw_transmit_all_ones, ja_in_tx_path, source_irq_pending, reg_wr, reg_rd} = 5'h08;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    n_fail      = 0;
    comparisons = 0;
    ce          = 1'h1;
    repeat (20) cyc;
    chk_bit(irq_out, 1'h0);
    rst_b     = 1'h1;
    host_mode = 1'h1;
    cyc;
    rd_chk(`ADDR_IRQ_ENABLE, 8'h00);
    rd_chk(`ADDR_IRQ_PENDING, 8'h00);
    rd_chk(`ADDR_DEV_ID, `DEV_ID_VALUE);
    rd_chk(`ADDR_DEV_REV, `DEV_REV_VALUE);
    reg_write(`ADDR_DEV_ID, 8'h00);
    rd_chk(`ADDR_DEV_ID, `DEV_ID_VALUE);
    rd_chk(8'h22, 8'h00);
    source_irq_pending = 1'h1;
    repeat (2) cyc;
    chk_bit(irq_out, 1'h0);
    rd_chk(`ADDR_IRQ_PENDING, 8'h01);
    reg_write(`ADDR_IRQ_ENABLE, 8'h01);
    chk_bit(irq_out, 1'h1);
    rd_chk(`ADDR_IRQ_ENABLE, 8'h01);
    // Clock enable low must hold the interrupt output as it stands
    ce                 = 1'h0;
    source_irq_pending = 1'h0;
    repeat (2) cyc;
    chk_bit(irq_out, 1'h1);
    ce = 1'h1;
    cyc;
    chk_bit(irq_out, 1'h0);
    reg_write(`ADDR_IRQ_ENABLE, 8'h00);
    for (int h = 0; h < 2; h++) begin
      for (int c = 0; c < 4; c++) begin
        host_mode = h[0];
        {hw_remote_loop, hw_local_loop} = h[0] ? ~c[1:0] : c[1:0];
        if (h == 1)
          reg_write(`ADDR_CHAN_CTRL, {3'h0, c[1:0], 3'h0});
        check_path(c[1:0]);
      end
    end
    {hw_remote_loop, hw_local_loop} = 2'h0;
    ja_in_tx_path = 1'h0;
    reg_write(`ADDR_CHAN_CTRL, 8'h10);
    check_path(2'h2);
    ja_in_tx_path = 1'h1;
    reg_write(`ADDR_CHAN_CTRL, 8'h02);
    check_all_ones;
    reg_write(`ADDR_CHAN_CTRL, 8'h00);
    host_mode            = 1'h0;
    hw_transmit_all_ones = 1'h1;
    check_all_ones;
    hw_transmit_all_ones = 1'h0;
    host_mode            = 1'h1;
    for (int r = 0; r < 2; r++) begin
      rate_is_e3 = r[0];
      reg_write(`ADDR_CHAN_CTRL, 8'h08);
      reg_write(`ADDR_CHAN_CTRL, 8'h28);
      chk_bit(rx_negative_or_violation_out, 1'h1);
      reg_read(`ADDR_CHAN_STAT, d);
      chk_bit(d[`STAT_SYNC_LOST], 1'h1);
      wait_sync;
      reg_read(`ADDR_CHAN_STAT, d);
      chk_bit(d[`STAT_SYNC_LOST], 1'h0);
      reg_read(`ADDR_ERR_HIGH, d);
      rd_chk(`ADDR_ERR_LOW, 8'h00);
      reg_write(`ADDR_CHAN_CTRL, 8'h29);
      count_pulses(8'h01);
      reg_write(`ADDR_CHAN_CTRL, 8'h28);
      count_pulses(8'h00);
      reg_write(`ADDR_CHAN_CTRL, 8'h29);
      count_pulses(8'h01);
      reg_write(`ADDR_CHAN_CTRL, 8'h29);
      count_pulses(8'h00);
      rd_chk(`ADDR_ERR_LOW, 8'h02);
      rd_chk(`ADDR_ERR_HOLD, 8'h00);
      reg_write(`ADDR_CHAN_CTRL, 8'h28);
      reg_write(`ADDR_CHAN_CTRL, 8'h29);
      count_pulses(8'h01);
      rd_chk(`ADDR_ERR_HIGH, 8'h00);
      rd_chk(`ADDR_ERR_HOLD, 8'h01);
      rd_chk(`ADDR_ERR_LOW, 8'h00);
    end
    host_mode = 1'h0;
    check_path(2'h0);
    host_mode  = 1'h1;
    rate_is_e3 = 1'h0;
    // Pattern off first so the generator restarts from its seed, never from a dead state
    reg_write(`ADDR_CHAN_CTRL, 8'h08);
    reg_write(`ADDR_CHAN_CTRL, 8'h28);
    for (int i = 0; i < 32; i++) begin
      cyc;
      first_bits[i] = line_tx_positive;
    end
    repeat (32767 - 32) cyc;
    for (int i = 0; i < 32; i++) begin
      cyc;
      later_bits[i] = line_tx_positive;
    end
    chk_bit(|first_bits & ~&first_bits, 1'h1);
    for (int k = 0; k < 4; k++)
      chk_byte(later_bits[k*8 +: 8], first_bits[k*8 +: 8]);
    test_done;
  end
endmodule : test_liu_diagnostics_prbs_loopback
